// [verilog/rsfl_defines.svh]
// Register indices, field positions, reset values and timing constants
`ifndef RSFL_DEFINES_SVH
`define RSFL_DEFINES_SVH

// Word indices on the Avalon-MM port (byte offset is four times these)
`define RSFL_IDX_THR      3'h0
`define RSFL_IDX_CTRL     3'h1
`define RSFL_IDX_WEN      3'h2
`define RSFL_IDX_STAT     3'h3
`define RSFL_IDX_IRQS     3'h4
`define RSFL_IDX_IRQM     3'h5

// Threshold code: power-on value and the valid codes
`define RSFL_THR_POR      8'h55
`define RSFL_THR_V0       8'h55
`define RSFL_THR_V1       8'h33
`define RSFL_THR_V2       8'h99
`define RSFL_THR_V3       8'haa

// Watchdog enable code: power-on value and the other enabling code
`define RSFL_WEN_POR      5'h0a
`define RSFL_WEN_ALT      5'h15

// Control register field positions
`define RSFL_CTRL_KEEP    7
`define RSFL_CTRL_LOW_VOLTAGE_RESET_FLAG    2
`define RSFL_CTRL_LRF     1
`define RSFL_CTRL_WRF     0

// Status register field positions
`define RSFL_STAT_TO      1
`define RSFL_STAT_PDF     0

// Interrupt status bit positions
`define RSFL_IRQ_LV       0
`define RSFL_IRQ_THR      1
`define RSFL_IRQ_WEN      2
`define RSFL_IRQ_WDT      3

// Timing
// Third synced slow edge lands two to three slow periods after detection
`define RSFL_LOW_SPEED_INTERNAL_OSC_EDGES   2'h3
`define RSFL_SETTLE_HIGH_SPEED_INTERNAL_OSC  5'h0f
`define RSFL_SETTLE_LOW_SPEED_INTERNAL_OSC  5'h01
`define RSFL_CLK_NS       25.0
`define RSFL_RST_DELAY_MS 16.7

`endif

// [verilog/rsfl_pkg.sv]
// Types shared by the reset source and flag logic
package rsfl_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT,
    S_HOLD,
    S_SETTLE
  } rsfl_state_t;

  typedef enum logic [2:0] {
    C_POR,
    C_LV,
    C_THR,
    C_WEN,
    C_WDT
  } rsfl_cause_t;

endpackage : rsfl_pkg

// [verilog/rsfl_top.sv]
// Reset source sequencing, sticky reset flags and register slave
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rsfl_defines.svh"

module rsfl_top #(
  parameter int unsigned RST_DELAY_CYC =
    int'(`RSFL_RST_DELAY_MS * 1.0e6 / `RSFL_CLK_NS)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        low_speed_internal_osc_clk_i,
  input  wire logic        low_supply_i,
  input  wire logic        sleep_mode_i,
  input  wire logic        sys_on_high_speed_internal_osc_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             full_reset_o,
  output logic             pc_sp_clear_o,
  output logic             wake_resume_o,
  output logic             irq_o
);
  import rsfl_pkg::*;

  localparam int HOLD_W = $clog2(RST_DELAY_CYC + 1);

  rsfl_state_t      st;
  rsfl_cause_t      cause;
  logic [HOLD_W-1:0] hold_cnt;
  logic [1:0]       edge_cnt;
  logic [4:0]       settle_cnt;
  logic [4:0]       settle_len;
  logic [2:0]       low_speed_internal_osc_sync;
  logic [1:0]       low_sync;
  logic             sleep_q;
  logic             ack;
  logic [7:0]       thr_code;
  logic [4:0]       wen_code;
  logic             keep_sysclk;
  logic [2:0]       rst_flags;
  logic [2:0]       flag_set;
  logic             to_flag;
  logic             pdf_flag;
  logic [3:0]       irq_status;
  logic [3:0]       irq_mask;
  logic [3:0]       irq_set;
  logic [31:0]      next_rdata;
  logic             thr_valid;
  logic             wen_valid;
  logic             lv_evt;
  logic             idle;
  logic             wdt_run;
  logic             wdt_slp;
  logic             wait_done;
  logic             enter_hold;
  logic             wr_done;
  logic             rd_done;

  // Slow clock and low supply pass two flops; third slow clock stage only feeds edge detect
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      low_speed_internal_osc_sync <= 3'h0;
      low_sync  <= 2'h0;
      sleep_q   <= 1'b0;
    end else begin
      low_speed_internal_osc_sync <= {low_speed_internal_osc_sync[1:0], low_speed_internal_osc_clk_i};
      low_sync  <= {low_sync[0], low_supply_i};
      sleep_q   <= sleep_mode_i;
    end
  end

  assign thr_valid = (thr_code == `RSFL_THR_V0) ||
                     (thr_code == `RSFL_THR_V1) ||
                     (thr_code == `RSFL_THR_V2) ||
                     (thr_code == `RSFL_THR_V3);
  assign wen_valid = (wen_code == `RSFL_WEN_POR) ||
                     (wen_code == `RSFL_WEN_ALT);

  assign lv_evt = low_sync[1] & ~sleep_mode_i;

  // Events are only taken while no sequence runs
  assign idle    = (st == S_IDLE);
  assign wdt_run = idle & wdt_timeout_i & ~sleep_mode_i;
  assign wdt_slp = idle & wdt_timeout_i & sleep_mode_i;
  assign flag_set = {idle & lv_evt, idle & ~thr_valid, idle & ~wen_valid};
  assign irq_set  = {wdt_run | wdt_slp, flag_set[0], flag_set[1],
                     flag_set[2]};
  assign wait_done = (st == S_WAIT) & low_speed_internal_osc_sync[1] & ~low_speed_internal_osc_sync[2] &
                     (edge_cnt == `RSFL_LOW_SPEED_INTERNAL_OSC_EDGES - 2'h1);
  assign enter_hold = wait_done | (wdt_run & ~lv_evt & thr_valid &
                                   wen_valid);

  // Sequencer: wait on slow clock edges, hold reset, or settle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      // power-on holds the core in reset
      st            <= S_HOLD;
      cause         <= C_POR;
      hold_cnt      <= '0;
      edge_cnt      <= 2'h0;
      settle_cnt    <= 5'h00;
      settle_len    <= `RSFL_SETTLE_LOW_SPEED_INTERNAL_OSC;
      full_reset_o  <= 1'b1;
      pc_sp_clear_o <= 1'b0;
      wake_resume_o <= 1'b0;
    end else begin
      pc_sp_clear_o <= 1'b0;
      wake_resume_o <= 1'b0;
      unique case (st)
        S_IDLE: begin
          if (lv_evt || !thr_valid || !wen_valid) begin
            // bad code waits on slow clock edges
            st       <= S_WAIT;
            edge_cnt <= 2'h0;
            if (lv_evt) begin
              cause <= C_LV;
            end else if (!thr_valid) begin
              cause <= C_THR;
            end else begin
              // bad enable code takes same path
              cause <= C_WEN;
            end
          end else if (wdt_run) begin
            st           <= S_HOLD;
            cause        <= C_WDT;
            hold_cnt     <= '0;
            full_reset_o <= 1'b1;
          end else if (wdt_slp) begin
            // sleeping timeout clears PC and SP only
            st            <= S_SETTLE;
            pc_sp_clear_o <= 1'b1;
            settle_cnt    <= 5'h00;
            settle_len <= sys_on_high_speed_internal_osc_i ? `RSFL_SETTLE_HIGH_SPEED_INTERNAL_OSC
                                        : `RSFL_SETTLE_LOW_SPEED_INTERNAL_OSC;
          end
        end
        S_WAIT: begin
          // reset starts after the slow clock edges
          if (wait_done) begin
            st           <= S_HOLD;
            hold_cnt     <= '0;
            full_reset_o <= 1'b1;
          end else if (low_speed_internal_osc_sync[1] && !low_speed_internal_osc_sync[2]) begin
            edge_cnt <= edge_cnt + 2'h1;
          end
        end
        S_HOLD: begin
          // reset held for the reset delay
          if (hold_cnt == HOLD_W'(RST_DELAY_CYC - 1)) begin
            st           <= S_IDLE;
            full_reset_o <= 1'b0;
          end else begin
            hold_cnt <= hold_cnt + HOLD_W'(1);
          end
        end
        S_SETTLE: begin
          if (settle_cnt == settle_len - 5'h01) begin
            st            <= S_IDLE;
            wake_resume_o <= 1'b1;
          end else begin
            settle_cnt <= settle_cnt + 5'h01;
          end
        end
      endcase
    end
  end

  // Bus handshake: one wait state on every access
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_done = avs_write_i & ack;
  assign rd_done = avs_read_i & ack;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  // Threshold code; restore beats a coincident write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      thr_code <= `RSFL_THR_POR;
    end else if (wait_done && cause == C_THR) begin
      // corrupt code restored as reset begins
      thr_code <= `RSFL_THR_POR;
    end else if (wr_done && avs_address_i == `RSFL_IDX_THR) begin
      thr_code <= avs_writedata_i[7:0];
    end
  end

  // Watchdog enable code back to default on any full reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wen_code <= `RSFL_WEN_POR;
    end else if (enter_hold) begin
      wen_code <= `RSFL_WEN_POR;
    end else if (wr_done && avs_address_i == `RSFL_IDX_WEN) begin
      wen_code <= avs_writedata_i[4:0];
    end
  end

  // Idle clock keep bit returns to zero on a full reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || enter_hold) begin
      keep_sysclk <= 1'b0;
    end else if (wr_done && avs_address_i == `RSFL_IDX_CTRL) begin
      keep_sysclk <= avs_writedata_i[`RSFL_CTRL_KEEP];
    end
  end

  // Sticky cause flags, one per bit; only software clears
  for (genvar i = 0; i < 3; i++) begin : g_flag
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        rst_flags[i] <= 1'b0;
      end else if (flag_set[i]) begin
        rst_flags[i] <= 1'b1;
      end else if (wr_done && avs_address_i == `RSFL_IDX_CTRL) begin
        // software write is the only clear
        rst_flags[i] <= avs_writedata_i[i];
      end
    end
  end

  // Timeout and powerdown flags
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      to_flag  <= 1'b0;
      pdf_flag <= 1'b0;
    end else begin
      if (wdt_run || wdt_slp) begin
        to_flag <= 1'b1;
      end else if (wr_done && avs_address_i == `RSFL_IDX_STAT) begin
        to_flag <= avs_writedata_i[`RSFL_STAT_TO];
      end
      if (wdt_slp || (sleep_mode_i && !sleep_q)) begin
        pdf_flag <= 1'b1;
      end else if (wr_done && avs_address_i == `RSFL_IDX_STAT) begin
        pdf_flag <= avs_writedata_i[`RSFL_STAT_PDF];
      end
    end
  end

  // Interrupt status clears on read; events in the completion cycle survive, events in the wait cycle are lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_status <= 4'h0;
    end else if (rd_done && avs_address_i == `RSFL_IDX_IRQS) begin
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_mask <= 4'h0;
    end else if (wr_done && avs_address_i == `RSFL_IDX_IRQM) begin
      irq_mask <= avs_writedata_i[3:0];
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // Read mux; unmapped words read zero
  always_comb begin
    next_rdata = 32'h0;
    unique case (avs_address_i)
      `RSFL_IDX_THR:  next_rdata[7:0] = thr_code;
      `RSFL_IDX_CTRL: next_rdata[7:0] = {keep_sysclk, 4'h0, rst_flags};
      `RSFL_IDX_WEN:  next_rdata[4:0] = wen_code;
      `RSFL_IDX_STAT: next_rdata[1:0] = {to_flag, pdf_flag};
      `RSFL_IDX_IRQS: next_rdata[3:0] = irq_status;
      `RSFL_IDX_IRQM: next_rdata[3:0] = irq_mask;
      default:        next_rdata = 32'h0;
    endcase
  end

  // Read data captured in the wait cycle, stands at completion
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_valid_code_quiet: assert property (
    idle && thr_valid && wen_valid && !lv_evt && !wdt_timeout_i
    |=> st == S_IDLE)
    else $error("valid codes still started a sequence");

  a_thr_restore: assert property (
    wait_done && cause == C_THR
    |=> thr_code == `RSFL_THR_POR && full_reset_o)
    else $error("corrupt threshold not restored at reset");

  a_lv_keeps_code: assert property (
    wait_done && cause == C_LV && !(wr_done &&
      avs_address_i == `RSFL_IDX_THR)
    |=> full_reset_o && $stable(thr_code))
    else $error("low-voltage reset altered threshold code");

  a_lv_flag_set: assert property (
    idle && lv_evt |=> rst_flags[`RSFL_CTRL_LOW_VOLTAGE_RESET_FLAG] ##1 st != S_IDLE)
    else $error("low-voltage flag not set");

  a_ctrl_zero_bits: assert property (
    rd_done && avs_address_i == `RSFL_IDX_CTRL
    |-> avs_readdata_o[6:3] == 4'h0)
    else $error("control bits 6..3 not zero");

  a_run_wdt_reset: assert property (
    wdt_run && thr_valid && wen_valid && !lv_evt
    |=> full_reset_o && to_flag && cause == C_WDT)
    else $error("running timeout reset missing");

  a_sleep_wdt_clear: assert property (
    wdt_slp |=> pc_sp_clear_o && !full_reset_o && to_flag && pdf_flag)
    else $error("sleeping timeout handled wrongly");

  a_high_speed_internal_osc_settle: assert property (
    pc_sp_clear_o && settle_len == `RSFL_SETTLE_HIGH_SPEED_INTERNAL_OSC
    |-> ##15 wake_resume_o)
    else $error("high-speed settle not 15 cycles");

  a_low_speed_internal_osc_settle: assert property (
    pc_sp_clear_o && settle_len == `RSFL_SETTLE_LOW_SPEED_INTERNAL_OSC
    |-> ##1 wake_resume_o)
    else $error("low-speed settle not 1 cycle");

  a_hold_length: assert property (
    $fell(full_reset_o)
    |-> $past(hold_cnt) == HOLD_W'(RST_DELAY_CYC - 1))
    else $error("reset hold length wrong");

  a_brownout_off: assert property (
    idle && sleep_mode_i && thr_valid && wen_valid && !wdt_timeout_i
    |=> st == S_IDLE)
    else $error("brown-out acted in power-down");

  a_set_beats_clr: assert property (
    flag_set[`RSFL_CTRL_WRF] && wr_done &&
    avs_address_i == `RSFL_IDX_CTRL
    |=> rst_flags[`RSFL_CTRL_WRF])
    else $error("software clear beat hardware set");

endmodule : rsfl_top

// [testbench/rsfl_top_tb.sv]
// Self-checking bench for the reset source and flag logic
`timescale 1ns/1ps
`include "rsfl_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module rsfl_top_tb;
  import rsfl_pkg::*;
  localparam int unsigned HOLD = 20;

  logic        clk_sys_i       = 1'b0;
  logic        rst_i           = 1'b1;
  logic        low_speed_internal_osc_clk_i      = 1'b0;
  logic        low_supply_i    = 1'b0;
  logic        sleep_mode_i    = 1'b0;
  logic        sys_on_high_speed_internal_osc_i   = 1'b1;
  logic        wdt_timeout_i   = 1'b0;
  logic [2:0]  avs_address_i   = 3'h0;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        full_reset_o;
  logic        pc_sp_clear_o;
  logic        wake_resume_o;
  logic        irq_o;
  logic [3:0]  lc              = 4'h0;
  logic [7:0]  codes [4]       = '{8'h55, 8'h33, 8'h99, 8'haa};
  int          failures        = 0;
  int          tests_run       = 0;
  int          cyc             = 0;
  int          n, pcn, rsn;

  rsfl_top #(.RST_DELAY_CYC(HOLD)) u_dut (
    .clk_sys_i         (clk_sys_i),
    .rst_i             (rst_i),
    .low_speed_internal_osc_clk_i        (low_speed_internal_osc_clk_i),
    .low_supply_i      (low_supply_i),
    .sleep_mode_i      (sleep_mode_i),
    .sys_on_high_speed_internal_osc_i     (sys_on_high_speed_internal_osc_i),
    .wdt_timeout_i     (wdt_timeout_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .full_reset_o      (full_reset_o),
    .pc_sp_clear_o     (pc_sp_clear_o),
    .wake_resume_o     (wake_resume_o),
    .irq_o             (irq_o)
  );

  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  // Slow oscillator, 16 system cycles a period, unrelated to bus traffic
  always @(posedge clk_sys_i) begin
    lc         <= lc + 4'h1;
    low_speed_internal_osc_clk_i <= lc[3];
  end

  // Hang guard, far above the fewer than a thousand cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // One Avalon access; waitrequest and read data taken at the rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_read_i      <= ~wr;
    avs_write_i     <= wr;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    `CHK("waitrequest", 1'b1, k < 20)
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [2:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask : rdc

  // Cycles until the core reset reaches a level, bounded
  task automatic wait_rst(input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (full_reset_o !== lvl && k < 300);
  endtask : wait_rst

  // Watchdog pulse of one cycle, raised and dropped on rising edges
  task automatic wdt_pulse;
    @(posedge clk_sys_i);
    wdt_timeout_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_timeout_i <= 1'b0;
  endtask : wdt_pulse

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("por hold", 1'b1, full_reset_o)
    rdc("thr", `RSFL_IDX_THR, 32'h55);
    rdc("ctrl", `RSFL_IDX_CTRL, 32'h0);
    rdc("wen", `RSFL_IDX_WEN, 32'h0a);
    rdc("stat", `RSFL_IDX_STAT, 32'h0);
    rdc("irqm", `RSFL_IDX_IRQM, 32'h0);
    wr(3'h7, 32'hff);
    rdc("unmapped", 3'h7, 32'h0);
    wait_rst(1'b0, n);
    for (int i = 0; i < 4; i++) begin
      wr(`RSFL_IDX_THR, {24'h0, codes[i]});
      repeat (60) @(negedge clk_sys_i);
      `CHK("valid thr", 1'b0, full_reset_o)
      rdc("thr keep", `RSFL_IDX_THR, {24'h0, codes[i]});
    end
    wr(`RSFL_IDX_WEN, 32'h15);
    repeat (60) @(negedge clk_sys_i);
    `CHK("valid wen", 1'b0, full_reset_o)
    wr(`RSFL_IDX_CTRL, 32'hff);
    rdc("ctrl bits", `RSFL_IDX_CTRL, 32'h87);
    wr(`RSFL_IDX_CTRL, 32'h0);
    rdc("ctrl clear", `RSFL_IDX_CTRL, 32'h0);
    wr(`RSFL_IDX_IRQM, 32'hf);
    wr(`RSFL_IDX_THR, 32'h12);
    wait_rst(1'b1, n);
    `CHK("thr delay", 1'b1, n >= 32 && n <= 52)
    rdc("thr restore", `RSFL_IDX_THR, 32'h55);
    rdc("thr flag", `RSFL_IDX_CTRL, 32'h02);
    @(negedge clk_sys_i);
    `CHK("irq high", 1'b1, irq_o)
    rdc("irqs", `RSFL_IDX_IRQS, 32'h02);
    rdc("irqs clr", `RSFL_IDX_IRQS, 32'h0);
    @(negedge clk_sys_i);
    `CHK("irq low", 1'b0, irq_o)
    wait_rst(1'b0, n);
    // low supply keeps code and status
    wr(`RSFL_IDX_THR, 32'h99);
    wr(`RSFL_IDX_STAT, 32'h2);
    @(posedge clk_sys_i);
    low_supply_i <= 1'b1;
    // Control clear lands on the very edge the low supply is seen
    wr(`RSFL_IDX_CTRL, 32'h0);
    wait_rst(1'b1, n);
    `CHK("lv delay", 1'b1, n >= 32 && n <= 52)
    @(posedge clk_sys_i);
    low_supply_i <= 1'b0;
    rdc("lv thr", `RSFL_IDX_THR, 32'h99);
    rdc("lv flag", `RSFL_IDX_CTRL, 32'h04);
    rdc("lv stat", `RSFL_IDX_STAT, 32'h2);
    rdc("lv irqs", `RSFL_IDX_IRQS, 32'h1);
    wait_rst(1'b0, n);
    wr(`RSFL_IDX_CTRL, 32'h0);
    @(posedge clk_sys_i);
    sleep_mode_i <= 1'b1;
    low_supply_i <= 1'b1;
    repeat (80) @(negedge clk_sys_i);
    `CHK("pd no lv", 1'b0, full_reset_o)
    @(posedge clk_sys_i);
    low_supply_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    sleep_mode_i <= 1'b0;
    wr(`RSFL_IDX_WEN, 32'h1f);
    wait_rst(1'b1, n);
    `CHK("wen delay", 1'b1, n >= 32 && n <= 52)
    rdc("wen flag", `RSFL_IDX_CTRL, 32'h01);
    rdc("wen restore", `RSFL_IDX_WEN, 32'h0a);
    rdc("wen irqs", `RSFL_IDX_IRQS, 32'h4);
    wait_rst(1'b0, n);
    rdc("wen sticky", `RSFL_IDX_CTRL, 32'h01);
    wr(`RSFL_IDX_STAT, 32'h1);
    wdt_pulse();
    @(negedge clk_sys_i);
    `CHK("wdt reset", 1'b1, full_reset_o)
    n = 1;
    @(negedge clk_sys_i);
    while (full_reset_o === 1'b1 && n < 300) begin
      n++;
      @(negedge clk_sys_i);
    end
    `CHK("hold len", HOLD, n)
    rdc("wdt stat", `RSFL_IDX_STAT, 32'h3);
    rdc("wdt irqs", `RSFL_IDX_IRQS, 32'h8);
    // sleeping timeout on each clock source
    for (int h = 1; h >= 0; h--) begin
      @(posedge clk_sys_i);
      sleep_mode_i  <= 1'b1;
      sys_on_high_speed_internal_osc_i <= h[0];
      wr(`RSFL_IDX_STAT, 32'h0);
      wdt_pulse();
      pcn = 0;
      rsn = 0;
      for (int c = 1; c <= 30; c++) begin
        @(negedge clk_sys_i);
        if (pc_sp_clear_o === 1'b1 && pcn == 0) pcn = c;
        if (wake_resume_o === 1'b1 && rsn == 0) rsn = c;
      end
      `CHK("pc sp", 1, pcn)
      `CHK("settle", (h == 1) ? 16 : 2, rsn)
      `CHK("no full", 1'b0, full_reset_o)
      rdc("sleep stat", `RSFL_IDX_STAT, 32'h3);
      rdc("sleep irqs", `RSFL_IDX_IRQS, 32'h8);
      @(posedge clk_sys_i);
      sleep_mode_i <= 1'b0;
    end
    tally_and_finish();
  end

endmodule : rsfl_top_tb
